// ---- pkg/pixel_brightness_curve_regs.svh ----
// Constants for the pixel brightness curve stage
`ifndef PIXEL_BRIGHTNESS_CURVE_REGS_SVH
`define PIXEL_BRIGHTNESS_CURVE_REGS_SVH

// Pixel and exponent widths
`define PIX_W 12
`define EXP_W 12
`define EXP_FRAC 10
// Full-scale brightness per output depth
`define FULL_8 12'h0ff
`define FULL_10 12'h3fc
`define FULL_12 12'hff0
// Exponent of exactly one in 2.10 fixed point
`define EXP_ONE 12'h400
// Exponent reset value: zero, curve inactive
`define EXP_RST 12'h000
// Largest exponent, one step below four
`define EXP_MAX 12'hfff
// Float exponent bias and shift base for 2.10 conversion
`define FLT_BIAS 8'h7f
`define FLT_SHIFT_BASE 9'h08c
// Depth of the input buffer
`define FIFO_DEPTH 8

`endif

// ---- pkg/pixel_brightness_curve_pkg.sv ----
// Types for the pixel brightness curve stage
package pixel_brightness_curve_pkg;

    // Output bit depth selection
    typedef enum logic [1:0] {
        DEPTH_8 = 2'b00,
        DEPTH_10 = 2'b01,
        DEPTH_12 = 2'b10
    } depth_mode_t;

    // How a pixel is handled in the pipe
    typedef enum logic [1:0] {
        KIND_CURVE = 2'b00,
        KIND_PASS = 2'b01,
        KIND_ZERO = 2'b10,
        KIND_FULL = 2'b11
    } pix_kind_t;

endpackage

// ---- pkg/pix_stream_if.sv ----
// Valid/ready pixel stream between the stage and its buffer
`timescale 1ns/10ps
interface pix_stream_if #(parameter int W = 12);
    logic [W-1:0] data; // Pixel word
    logic valid; // Word offered
    logic ready; // Word accepted

    // Party that offers words
    modport src(output data, output valid, input ready);
    // Party that takes words
    modport snk(input data, input valid, output ready);
endinterface

// ---- verilog/pix_fifo.sv ----
// Synchronous pixel FIFO with registered flags
`timescale 1ns/10ps
module pix_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    pix_stream_if.snk wr,
    pix_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH]; // Storage words
    logic [AW-1:0] wr_ptr_r; // Next slot to fill
    logic [AW-1:0] rd_ptr_r; // Oldest slot
    logic [CW-1:0] count_r; // Words held
    logic [CW-1:0] count_nxt;
    logic in_ready_r; // Not full
    logic out_valid_r; // Not empty
    logic push;
    logic pop;

    assign push = wr.valid & in_ready_r;
    assign pop = out_valid_r & rd.ready;
    assign wr.ready = in_ready_r;
    assign rd.valid = out_valid_r;
    assign rd.data = mem[rd_ptr_r];

    // Occupancy after this cycle
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + CW'(1);
        end else if (pop && !push) begin
            count_nxt = count_r - CW'(1);
        end
    end

    // Storage write, no reset needed on data
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= wr.data;
        end
    end

    // Pointers wrap at depth
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
            end
        end
    end

    // Count and flags registered so ready never ripples combinationally
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_r <= '0;
            in_ready_r <= 1'b0;
            out_valid_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            in_ready_r <= (count_nxt != CW'(DEPTH));
            out_valid_r <= (count_nxt != '0);
        end
    end
endmodule // pix_fifo

// ---- verilog/pixel_brightness_curve.sv ----
// Power-curve brightness correction stage with input buffer
//
// Notes on behaviour
// - Output is (in/full)^exponent times full-scale.
// - Full-scale is 255, 1020 or 4080.
// - Exponent one passes pixels unchanged.
// - Exponent below one brightens, above darkens.
// - Zero and full-scale inputs stay unchanged.
// - Correction acts only with lookup path enabled.
// - Correction active when exponent above zero.
// - Exponent spans zero to 3.99902, used as written.
// - Exponent written as float or raw field.
`timescale 1ns/10ps
`include "pixel_brightness_curve_regs.svh"
module pixel_brightness_curve (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic lut_enable,
    input wire logic [1:0] depth_mode,
    input wire logic [`EXP_W-1:0] exp_raw_wdata,
    input wire logic exp_raw_we,
    input wire logic [31:0] exp_float_wdata,
    input wire logic exp_float_we,
    output logic [`EXP_W-1:0] exp_value,
    output logic corr_active,
    input wire logic [`PIX_W-1:0] pix_in_data,
    input wire logic pix_in_valid,
    output logic pix_in_ready,
    output logic [`PIX_W-1:0] pix_out_data,
    output logic pix_out_valid,
    input wire logic pix_out_ready
);
    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Full-scale value for a depth setting
    function automatic logic [11:0] full_scale(input logic [1:0] m);
        unique case (pixel_brightness_curve_pkg::depth_mode_t'(m))
            pixel_brightness_curve_pkg::DEPTH_8: return `FULL_8;
            pixel_brightness_curve_pkg::DEPTH_10: return `FULL_10;
            default: return `FULL_12;
        endcase
    endfunction

    // Bowed log2: 4 integer bits, 11 fraction bits
    function automatic logic [14:0] log2_fix(input logic [11:0] x);
        logic [3:0] p;
        logic [22:0] sh;
        logic [23:0] bow; // Curvature term, m*(1-m) scaled
        p = 4'h0;
        for (int i = 0; i < 12; i++) begin
            if (x[i]) begin
                p = 4'(i);
            end
        end
        sh = {11'h000, x} << (4'd11 - p);
        // Bare mantissa reads up to 0.086 low, which an exponent of two
        // doubles; adding 11/32*m*(1-m) keeps it within 0.01
        bow = 24'(sh[10:0]) * 24'(12'h800 - {1'b0, sh[10:0]});
        bow = bow * 24'h00000b;
        // Still monotone, and never carries past the fraction
        return {p, sh[10:0] + {3'h0, bow[23:16]}};
    endfunction

    // Single float to unsigned 2.10, clamped to the field range
    function automatic logic [11:0] float_to_fix(input logic [31:0] f);
        logic [8:0] sh;
        logic [23:0] mant;
        logic [23:0] val;
        sh = `FLT_SHIFT_BASE - {1'b0, f[30:23]};
        mant = {1'b1, f[22:0]};
        val = mant >> sh[4:0];
        if (f[31] || f[30:23] == 8'h00) begin
            return 12'h000; // Negative or tiny: treat as zero
        end else if (f[30:23] > (`FLT_BIAS + 8'h01)) begin
            return `EXP_MAX; // Four or more saturates below four
        end else if (sh > 9'd23) begin
            return 12'h000; // Below one step
        end
        return val[11:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Exponent register

    logic [`EXP_W-1:0] exp_r; // Exponent in use, 2.10 fixed
    logic corr_active_r; // Curve applied to new pixels

    // Raw write takes priority when both arrive together
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            exp_r <= `EXP_RST;
        end else if (exp_raw_we) begin
            exp_r <= exp_raw_wdata;
        end else if (exp_float_we) begin
            exp_r <= float_to_fix(exp_float_wdata);
        end
    end

    // Status: lookup path on and exponent nonzero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            corr_active_r <= 1'b0;
        end else begin
            corr_active_r <= lut_enable && (exp_r != 12'h000);
        end
    end

    assign exp_value = exp_r;
    assign corr_active = corr_active_r;

    ////////////////////////////////////////////////////////////////////
    // Input buffer

    pix_stream_if #(.W(`PIX_W)) push_if ();
    pix_stream_if #(.W(`PIX_W)) pop_if ();

    assign push_if.data = pix_in_data;
    assign push_if.valid = pix_in_valid;
    assign pix_in_ready = push_if.ready;

    pix_fifo #(.W(`PIX_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .wr(push_if),
        .rd(pop_if)
    );

    ////////////////////////////////////////////////////////////////////
    // Pipeline: classify and log, scale by exponent, exp2 and rescale

    logic adv; // Whole pipe moves; stalls on output back-pressure
    logic out_valid_r;
    logic [`PIX_W-1:0] out_data_r;
    assign adv = !out_valid_r || pix_out_ready;
    assign pop_if.ready = adv;

    logic s1_v_r; // Stage 1 holds a pixel
    logic [11:0] s1_x_r; // Input pixel
    logic [11:0] s1_max_r; // Full scale
    logic [14:0] s1_d_r; // log2(full) - log2(in), >= 0
    logic [`EXP_W-1:0] s1_g_r; // Exponent snapshot
    pixel_brightness_curve_pkg::pix_kind_t s1_kind_r;
    pixel_brightness_curve_pkg::pix_kind_t kind_nxt;
    logic [11:0] max_c;

    // Classify each pixel; special cases bypass the curve
    always_comb begin
        max_c = full_scale(depth_mode);
        if (!lut_enable || exp_r == 12'h000 || exp_r == `EXP_ONE) begin
            kind_nxt = pixel_brightness_curve_pkg::KIND_PASS;
        end else if (pop_if.data == 12'h000) begin
            kind_nxt = pixel_brightness_curve_pkg::KIND_ZERO;
        end else if (pop_if.data >= max_c) begin
            kind_nxt = pixel_brightness_curve_pkg::KIND_FULL;
        end else begin
            kind_nxt = pixel_brightness_curve_pkg::KIND_CURVE;
        end
    end

    // Stage 1: normalise in the log domain
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_v_r <= 1'b0;
            s1_x_r <= '0;
            s1_max_r <= '0;
            s1_d_r <= '0;
            s1_g_r <= '0;
            s1_kind_r <= pixel_brightness_curve_pkg::KIND_PASS;
        end else if (adv) begin
            s1_v_r <= pop_if.valid;
            s1_x_r <= pop_if.data;
            s1_max_r <= max_c;
            s1_d_r <= log2_fix(max_c) - log2_fix(pop_if.data);
            s1_g_r <= exp_r;
            s1_kind_r <= kind_nxt;
        end
    end

    logic s2_v_r;
    logic [11:0] s2_x_r;
    logic [11:0] s2_max_r;
    logic [16:0] s2_e_r; // Attenuation in log2 units, 11 fraction bits
    pixel_brightness_curve_pkg::pix_kind_t s2_kind_r;
    logic [26:0] prod_c;
    assign prod_c = 27'(s1_d_r) * 27'(s1_g_r);

    // Stage 2: multiply log ratio by exponent; small exponents brighten
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s2_v_r <= 1'b0;
            s2_x_r <= '0;
            s2_max_r <= '0;
            s2_e_r <= '0;
            s2_kind_r <= pixel_brightness_curve_pkg::KIND_PASS;
        end else if (adv) begin
            s2_v_r <= s1_v_r;
            s2_x_r <= s1_x_r;
            s2_max_r <= s1_max_r;
            s2_e_r <= prod_c[26:10];
            s2_kind_r <= s1_kind_r;
        end
    end

    // Stage 3: full * 2^-e; fraction by linear approximation, which
    // trades a few percent of accuracy for no table
    logic [5:0] k_c;
    logic [12:0] mant_c;
    logic [24:0] scaled_c;
    logic [24:0] shifted_c;
    logic [11:0] curve_c;
    always_comb begin
        k_c = s2_e_r[16:11];
        mant_c = 13'h1000 - {2'b00, s2_e_r[10:0]};
        scaled_c = 25'(s2_max_r) * 25'(mant_c);
        shifted_c = scaled_c >> (6'd12 + k_c);
        if (k_c > 6'd12) begin
            curve_c = 12'h000;
        end else if (shifted_c[11:0] > s2_max_r) begin
            curve_c = s2_max_r;
        end else begin
            curve_c = shifted_c[11:0];
        end
    end

    // Output register; held while the sink stalls
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (adv) begin
            out_valid_r <= s2_v_r;
            unique case (s2_kind_r)
                pixel_brightness_curve_pkg::KIND_PASS: out_data_r <= s2_x_r;
                pixel_brightness_curve_pkg::KIND_ZERO: out_data_r <= 12'h000;
                pixel_brightness_curve_pkg::KIND_FULL: out_data_r <= s2_max_r;
                pixel_brightness_curve_pkg::KIND_CURVE: out_data_r <= curve_c;
            endcase
        end
    end

    assign pix_out_valid = out_valid_r;
    assign pix_out_data = out_data_r;
endmodule // pixel_brightness_curve

// ---- bench/pixel_brightness_curve_asserts.sv ----
// Port checker for the brightness curve stage
`timescale 1ns/10ps
`include "pixel_brightness_curve_regs.svh"
module pixel_brightness_curve_asserts (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic lut_enable,
    input wire logic [`EXP_W-1:0] exp_raw_wdata,
    input wire logic exp_raw_we,
    input wire logic [31:0] exp_float_wdata,
    input wire logic exp_float_we,
    input wire logic [`EXP_W-1:0] exp_value,
    input wire logic corr_active,
    input wire logic pix_in_valid,
    input wire logic pix_in_ready,
    input wire logic [`PIX_W-1:0] pix_out_data,
    input wire logic pix_out_valid,
    input wire logic pix_out_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [4:0] occ_r; // Pixels held inside the stage
    wire flt_only = exp_float_we && !exp_raw_we; // Float write alone
    ////////////////////////////////////////////////////////////////////
    // Taken minus delivered; an output with nothing inside is invented
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            occ_r <= 5'h00;
        end else begin
            occ_r <= occ_r + 5'(pix_in_valid && pix_in_ready)
                - 5'(pix_out_valid && pix_out_ready);
        end
    end
    reset_clear_a: assert property (disable iff (1'b0) srst |=>
        exp_value == `EXP_RST && !corr_active && !pix_out_valid)
        else $error("Outputs not cleared by reset");
    raw_write_a: assert property (exp_raw_we |=>
        exp_value == $past(exp_raw_wdata))
        else $error("Raw exponent not taken");
    float_one_a: assert property (flt_only &&
        exp_float_wdata == 32'h3f800000 |=> exp_value == `EXP_ONE)
        else $error("Float one not converted");
    float_neg_a: assert property (flt_only && exp_float_wdata[31] |=>
        exp_value == 12'h000)
        else $error("Negative float not zeroed");
    float_big_a: assert property (flt_only && !exp_float_wdata[31] &&
        exp_float_wdata[30:23] inside {[8'h81:8'hfe]} |=>
        exp_value == `EXP_MAX)
        else $error("Large float not clamped");
    exp_hold_a: assert property (!exp_raw_we && !exp_float_we |=>
        $stable(exp_value))
        else $error("Exponent changed without write");
    active_def_a: assert property (1'b1 |=> corr_active ==
        ($past(lut_enable) && $past(exp_value) != 12'h000))
        else $error("Active flag wrong");
    out_hold_a: assert property (pix_out_valid && !pix_out_ready |=>
        pix_out_valid && $stable(pix_out_data))
        else $error("Output dropped while stalled");
    out_cause_a: assert property (pix_out_valid |-> occ_r != 5'h00)
        else $error("Output without input");
endmodule // pixel_brightness_curve_asserts
bind pixel_brightness_curve pixel_brightness_curve_asserts u_chk (
    .sys_clk, .srst, .lut_enable, .exp_raw_wdata, .exp_raw_we,
    .exp_float_wdata, .exp_float_we, .exp_value, .corr_active,
    .pix_in_valid, .pix_in_ready, .pix_out_data, .pix_out_valid,
    .pix_out_ready
);

// ---- bench/pix_sink_model.sv ----
// Output formatter model taking pixels, promptly or with stalls
`timescale 1ns/10ps
`include "pixel_brightness_curve_regs.svh"
module pix_sink_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`PIX_W-1:0] pix_out_data,
    input wire logic pix_out_valid,
    input wire logic [1:0] mode,
    output logic pix_out_ready
);
    logic [`PIX_W-1:0] got[$]; // Pixels taken, in arrival order
    logic tgl_r = 1'b0; // Phase of alternating stall
    ////////////////////////////////////////////////////////////////////
    // Mode 0 prompt, 1 holds off, 2 every other cycle
    always @(posedge sys_clk) begin
        if (pix_out_valid && pix_out_ready && !srst) begin
            got.push_back(pix_out_data);
        end
        tgl_r <= !tgl_r;
        pix_out_ready <= (mode == 2'd0) || (mode == 2'd2 && tgl_r);
    end
endmodule // pix_sink_model

// ---- bench/pixel_brightness_curve_test.sv ----
// Self-checking bench for the brightness curve stage
`timescale 1ns/10ps
`include "pixel_brightness_curve_regs.svh"
module pixel_brightness_curve_test;
    logic sys_clk = 1'b0; // 8 ns pixel clock
    logic srst = 1'b1; // Held for four cycles
    logic lut_enable = 1'b0;
    logic [1:0] depth_mode = 2'b10;
    logic [`EXP_W-1:0] exp_raw_wdata = 12'h000;
    logic exp_raw_we = 1'b0;
    logic [31:0] exp_float_wdata = 32'h00000000;
    logic exp_float_we = 1'b0;
    logic [`PIX_W-1:0] pix_in_data = 12'h000;
    logic pix_in_valid = 1'b0;
    logic [1:0] mode = 2'd0; // Far side stall pattern
    logic [`EXP_W-1:0] exp_value;
    logic corr_active, pix_in_ready, pix_out_valid, pix_out_ready;
    logic [`PIX_W-1:0] pix_out_data;
    int n_mismatch = 0;
    int tests_run = 0;
    int cur_exp = 0; // Exponent the bench last wrote
    int full = 4080; // Full scale of the chosen depth
    bit took; // Last offer accepted
    int exp_q[$], tol_q[$]; // Expected pixels and tolerances
    pixel_brightness_curve dut (.sys_clk, .srst, .lut_enable, .depth_mode,
        .exp_raw_wdata, .exp_raw_we, .exp_float_wdata, .exp_float_we,
        .exp_value, .corr_active, .pix_in_data, .pix_in_valid,
        .pix_in_ready, .pix_out_data, .pix_out_valid, .pix_out_ready);
    pix_sink_model sink (.sys_clk, .srst, .pix_out_data, .pix_out_valid,
        .mode, .pix_out_ready);
    always #4 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk_val(input logic [11:0] g, input logic [11:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Approximate curve, so a tolerance band is allowed
    task automatic chk_pix(input logic [11:0] g, input int e, input int t);
        int d;
        d = int'(g) - e;
        tests_run++;
        if (^g === 1'bx || d > t || d < -t) begin
            n_mismatch++;
            $display("Error %0t: pixel %h expected %0d", $time, g, e);
        end
    endtask
    // One write pulse, then wait until the active flag has followed
    task automatic wr_exp(input bit r, input bit f, input logic [11:0] rv,
                          input logic [31:0] fv);
        exp_raw_wdata <= rv;
        exp_float_wdata <= fv;
        exp_raw_we <= r;
        exp_float_we <= f;
        tick(1);
        exp_raw_we <= 1'b0;
        exp_float_we <= 1'b0;
        tick(2);
    endtask
    function automatic int ref_pix(int p);
        if (!lut_enable || cur_exp == 0 || p == 0) return p;
        if (p >= full) return full;
        return int'(full * ((real'(p) / full) ** (cur_exp / 1024.0)));
    endfunction
    // Offer a pixel; valid stays up for back-to-back traffic
    task automatic send(input int p, input int lim);
        int k;
        k = 0;
        pix_in_data <= 12'(p);
        pix_in_valid <= 1'b1;
        do begin
            tick(1);
            k++;
        end while (pix_in_ready !== 1'b1 && k < lim);
        took = (pix_in_ready === 1'b1);
        if (took) begin
            exp_q.push_back(ref_pix(p));
            tol_q.push_back((!lut_enable || cur_exp inside {0, 1024} ||
                p == 0 || p >= full) ? 0 : full * 6 / 100);
        end
    endtask
    task automatic drain;
        int k;
        k = 0;
        pix_in_valid <= 1'b0;
        while (sink.got.size() < exp_q.size() && k < 500) begin
            tick(1);
            k++;
        end
        chk_val(12'(sink.got.size()), 12'(exp_q.size()));
        while (exp_q.size() > 0 && sink.got.size() > 0) begin
            chk_pix(sink.got.pop_front(), exp_q.pop_front(),
                tol_q.pop_front());
        end
        exp_q.delete();
        tol_q.delete();
        sink.got.delete();
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        tick(20000);
        n_mismatch++;
        end_sim();
    end
    // Float words for the write test and the exponents they must give
    logic [31:0] fv [6] = '{32'h0, 32'h3fc00000, 32'h3fc00000,
        32'h40800000, 32'hbf800000, 32'h3f800000};
    logic [11:0] ev [6] = '{12'hfff, 12'h123, 12'h600, 12'hfff,
        12'h000, 12'h400};
    initial begin
        int n;
        tick(4);
        srst <= 1'b0;
        tick(1);
        chk_val(exp_value, `EXP_RST);
        chk_val(12'(corr_active), 12'h000);
        $display("Test reset done");
        // Raw only, both at once, then floats of 1.5, 4, -1 and 1
        for (int i = 0; i < 6; i++) begin
            wr_exp(i < 2, i != 0, i ? 12'h123 : 12'hfff, fv[i]);
            chk_val(exp_value, ev[i]);
        end
        $display("Test exponent writes done");
        lut_enable <= 1'b1;
        // Code 11 is run as well; it must act as twelve bits
        for (int d = 0; d < 4; d++) begin
            depth_mode <= 2'(d);
            full = (d == 0) ? 255 : (d == 1) ? 1020 : 4080;
            for (int j = 0; j < 3; j++) begin
                cur_exp = 512 << j;
                wr_exp(1'b1, 1'b0, 12'(cur_exp), 32'h0);
                chk_val(12'(corr_active), 12'h001);
                for (int q = 0; q <= 4; q++) begin
                    send(full * q / 4, 50);
                end
                drain();
            end
        end
        $display("Test curves done");
        // Lookup path off, then exponent zero: both leave pixels alone
        for (int k = 0; k < 2; k++) begin
            lut_enable <= k[0];
            cur_exp = k ? 0 : 2048;
            wr_exp(1'b1, 1'b0, 12'(cur_exp), 32'h0);
            chk_val(12'(corr_active), 12'h000);
            for (int q = 0; q <= 4; q++) begin
                send(full * q / 4 + 1, 50);
            end
            drain();
        end
        $display("Test bypass done");
        // Fill against a stalled far side, then drain with stalls
        mode <= 2'd1;
        n = 0;
        took = 1'b1;
        while (took && n < 30) begin
            send(n * 37 + 5, 20);
            n += int'(took);
        end
        chk_val(12'(n >= 8 && n <= 11), 12'h001);
        mode <= 2'd2;
        drain();
        $display("Test buffer done");
        end_sim();
    end
endmodule // pixel_brightness_curve_test
